// *** hdl/slw_params.svh ***
// offsets, field positions and reset values of the stack limit watchpoint
// assumes byte addresses on a 12-bit apb address, one aligned word per register
`ifndef SLW_PARAMS_SVH
`define SLW_PARAMS_SVH
`define SLW_OFF_CTRL 12'h000
`define SLW_OFF_DCTL 12'h004
`define SLW_OFF_W1 12'h008
`define SLW_OFF_W2 12'h00C
`define SLW_OFF_AMASK 12'h010
`define SLW_OFF_DVAL 12'h014
`define SLW_OFF_EST 12'h018
`define SLW_OFF_DST 12'h01C
`define SLW_OFF_IST 12'h020
`define SLW_OFF_IMASK 12'h024
`define SLW_OFF_MPC 12'h028
`define SLW_CB_SLC 0
`define SLW_CB_EXT 1
`define SLW_CB_INT 2
`define SLW_CB_EVT 3
`define SLW_CB_MCK 4
`define SLW_CB_HALT 5
`define SLW_CB_WATCH 6
`define SLW_CB_USE 8
`define SLW_CB_HWO 12
`define SLW_IB_DSI 0
`define SLW_IB_MCK 1
`define SLW_IB_HALT 2
`define SLW_IB_CMP 3
`define SLW_CTRL_RST 32'h0000_0000
`define SLW_DCTL_RST 32'h0000_000F
`define SLW_MASK_RST 32'hFFFF_FFFF
`endif

// *** hdl/slw_pkg.sv ***
// types shared by the stack limit watchpoint
// assumes the constants of slw_params.svh
package slw_pkg;
   typedef logic [31:0] slw_word_t;
   typedef enum logic {SLW_IDLE = 1'b0, SLW_WAIT = 1'b1} slw_state_t;
   typedef enum logic [1:0] {
      SLW_CMP_EXACT = 2'b00,
      SLW_CMP_SET = 2'b01,
      SLW_CMP_DATA = 2'b10
   } slw_cmp_t;
endpackage : slw_pkg

// *** hdl/slw_top.sv ***
// stack limit checking on the two data watchpoints, with apb registers
// assumes the load/store pipeline holds each access until the verdict cycle
// and runs on pclk; all core inputs are synchronous to pclk
`timescale 1ns/1ps
`include "slw_params.svh"

module slw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire slw_pkg::slw_word_t pwdata,
   output logic pready,
   output slw_pkg::slw_word_t prdata,
   output logic pslverr,
   input wire logic acc_valid,
   input wire slw_pkg::slw_word_t acc_addr,
   input wire slw_pkg::slw_word_t acc_data,
   input wire logic acc_write,
   input wire logic acc_super,
   input wire logic acc_sp_base,
   input wire slw_pkg::slw_word_t acc_pc,
   input wire logic acc_done,
   input wire logic hi_pri_pending,
   output logic verdict_valid,
   output logic abort_acc,
   output logic dsi_req,
   output logic mchk_req,
   output logic dbg_int_req,
   output logic halt_req,
   output logic watch_out,
   output logic irq
);
   import slw_pkg::*;

   slw_word_t ctrl_reg, dctl_reg, w1_reg, w2_reg, amask_reg, dval_reg, mpc_reg;
   logic [1:0] est_reg, dst_reg, pend_reg;
   logic [3:0] ist_reg, imask_reg;
   slw_state_t st_reg, st_next;

   // one watchpoint: type, privilege and address/data qualification
   function automatic logic hit_f(input slw_word_t wa, input logic [5:0] cfg,
                                  input slw_word_t a, input slw_word_t d,
                                  input slw_word_t msk, input slw_word_t dv,
                                  input logic wr, input logic su);
      logic tq;
      logic pq;
      logic aq;
      tq = wr ? cfg[1] : cfg[0];
      pq = (cfg[3:2] == 2'h0) | ((cfg[3:2] == 2'h1) & su) | ((cfg[3:2] == 2'h2) & ~su);
      case (slw_cmp_t'(cfg[5:4]))
         SLW_CMP_SET: aq = ((a ^ wa) & msk) == 32'h0;
         SLW_CMP_DATA: aq = (a == wa) && (d == dv);
         default: aq = (a == wa);
      endcase
      return tq & pq & aq;
   endfunction

   // apb: zero-wait slave would need combinational read data, so answer a cycle late
   logic acc_ph, rd_cap, wr_fire, map_ok;
   assign acc_ph = psel & penable;
   assign rd_cap = acc_ph & ~pready;
   assign wr_fire = acc_ph & pready & pwrite & map_ok;
   assign map_ok = (paddr == `SLW_OFF_CTRL) | (paddr == `SLW_OFF_DCTL) | (paddr == `SLW_OFF_W1) |
                   (paddr == `SLW_OFF_W2) | (paddr == `SLW_OFF_AMASK) | (paddr == `SLW_OFF_DVAL) |
                   (paddr == `SLW_OFF_EST) | (paddr == `SLW_OFF_DST) | (paddr == `SLW_OFF_IST) |
                   (paddr == `SLW_OFF_IMASK) | (paddr == `SLW_OFF_MPC);

   slw_word_t rd_mux;
   assign rd_mux = (paddr == `SLW_OFF_CTRL) ? ctrl_reg :
                   (paddr == `SLW_OFF_DCTL) ? dctl_reg :
                   (paddr == `SLW_OFF_W1) ? w1_reg :
                   (paddr == `SLW_OFF_W2) ? w2_reg :
                   (paddr == `SLW_OFF_AMASK) ? amask_reg :
                   (paddr == `SLW_OFF_DVAL) ? dval_reg :
                   (paddr == `SLW_OFF_EST) ? {30'h0, est_reg} :
                   (paddr == `SLW_OFF_DST) ? {30'h0, dst_reg} :
                   (paddr == `SLW_OFF_IST) ? {28'h0, ist_reg} :
                   (paddr == `SLW_OFF_IMASK) ? {28'h0, imask_reg} :
                   (paddr == `SLW_OFF_MPC) ? mpc_reg : 32'h0;

   logic wr_ctrl, wr_dctl, wr_w1, wr_w2, wr_amask, wr_dval, wr_est, wr_dst, wr_ist, wr_imask;
   assign wr_ctrl = wr_fire & (paddr == `SLW_OFF_CTRL);
   assign wr_dctl = wr_fire & (paddr == `SLW_OFF_DCTL);
   assign wr_w1 = wr_fire & (paddr == `SLW_OFF_W1);
   assign wr_w2 = wr_fire & (paddr == `SLW_OFF_W2);
   assign wr_amask = wr_fire & (paddr == `SLW_OFF_AMASK);
   assign wr_dval = wr_fire & (paddr == `SLW_OFF_DVAL);
   assign wr_est = wr_fire & (paddr == `SLW_OFF_EST);
   assign wr_dst = wr_fire & (paddr == `SLW_OFF_DST);
   assign wr_ist = wr_fire & (paddr == `SLW_OFF_IST);
   assign wr_imask = wr_fire & (paddr == `SLW_OFF_IMASK);

   // control fields
   logic slc_en, ext_own, evt_en, mck_sel, halt_en, watch_en;
   logic [1:0] sl_use, hw_own;
   assign slc_en = ctrl_reg[`SLW_CB_SLC];
   assign ext_own = ctrl_reg[`SLW_CB_EXT];
   assign evt_en = ctrl_reg[`SLW_CB_EVT];
   assign mck_sel = ctrl_reg[`SLW_CB_MCK];
   assign halt_en = ctrl_reg[`SLW_CB_HALT];
   assign watch_en = ctrl_reg[`SLW_CB_WATCH];
   assign sl_use = ctrl_reg[`SLW_CB_USE+1:`SLW_CB_USE];
   assign hw_own = ctrl_reg[`SLW_CB_HWO+1:`SLW_CB_HWO];

   // watchpoint hits
   logic [1:0] hit, sl, sw_res, hw_res, nrm_hit;
   logic sw_hit, hw_hit;
   assign hit[0] = acc_valid & hit_f(w1_reg, {dctl_reg[9:8], dctl_reg[5:4], dctl_reg[1:0]},
                                     acc_addr, acc_data, amask_reg, dval_reg, acc_write, acc_super);
   assign hit[1] = acc_valid & hit_f(w2_reg, {dctl_reg[11:10], dctl_reg[7:6], dctl_reg[3:2]},
                                     acc_addr, acc_data, amask_reg, dval_reg, acc_write, acc_super);
   assign sl = {2{slc_en}} & sl_use;
   // internal ownership is not consulted for software-owned checking
   assign sw_res = hit & sl & ~hw_own;
   assign hw_res = hit & sl & hw_own & {2{ext_own & acc_sp_base}};
   assign sw_hit = |sw_res;
   assign hw_hit = |hw_res & ~sw_hit;
   assign nrm_hit = hit & ~sl & {2{evt_en}};

   // hardware-owned hit waits for the access to complete
   logic hw_fin;
   assign hw_fin = (st_reg == SLW_WAIT) & acc_done;
   always_comb begin
      case (st_reg)
         SLW_IDLE: st_next = hw_hit ? SLW_WAIT : SLW_IDLE;
         SLW_WAIT: st_next = (acc_done & ~hw_hit) ? SLW_IDLE : SLW_WAIT;
         default: st_next = SLW_IDLE;
      endcase
   end

   // sticky flags: a set in the clearing cycle survives
   logic [1:0] est_next, dst_next;
   logic [3:0] ist_set, ist_next;
   assign est_next = (est_reg & ~(wr_est ? pwdata[1:0] : 2'h0)) | (hw_fin ? pend_reg : 2'h0);
   assign dst_next = (dst_reg & ~(wr_dst ? pwdata[1:0] : 2'h0)) | nrm_hit;
   assign ist_set = {|nrm_hit, hw_fin & halt_en, sw_hit & mck_sel, sw_hit & ~mck_sel};
   assign ist_next = (ist_reg & ~(wr_ist ? pwdata[3:0] : 4'h0)) | ist_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_cap;
         prdata <= (rd_cap & ~pwrite) ? rd_mux : 32'h0;
         pslverr <= rd_cap & ~map_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `SLW_CTRL_RST;
         dctl_reg <= `SLW_DCTL_RST;
         w1_reg <= 32'h0;
         w2_reg <= 32'h0;
         amask_reg <= `SLW_MASK_RST;
         dval_reg <= 32'h0;
         imask_reg <= 4'h0;
      end else begin
         if (wr_ctrl) ctrl_reg <= pwdata;
         if (wr_dctl) dctl_reg <= pwdata;
         if (wr_w1) w1_reg <= pwdata;
         if (wr_w2) w2_reg <= pwdata;
         if (wr_amask) amask_reg <= pwdata;
         if (wr_dval) dval_reg <= pwdata;
         if (wr_imask) imask_reg <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= SLW_IDLE;
         pend_reg <= 2'h0;
         est_reg <= 2'h0;
         dst_reg <= 2'h0;
         ist_reg <= 4'h0;
         mpc_reg <= 32'h0;
      end else begin
         st_reg <= st_next;
         if (hw_hit) pend_reg <= hw_res;
         est_reg <= est_next;
         dst_reg <= dst_next;
         ist_reg <= ist_next;
         if (sw_hit & mck_sel) mpc_reg <= acc_pc;
      end
   end

   // core-facing outputs: verdict one cycle after the access is offered, halt and watch one cycle after completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         verdict_valid <= 1'b0;
         abort_acc <= 1'b0;
         dsi_req <= 1'b0;
         mchk_req <= 1'b0;
         dbg_int_req <= 1'b0;
         halt_req <= 1'b0;
         watch_out <= 1'b0;
         irq <= 1'b0;
      end else begin
         verdict_valid <= acc_valid;
         abort_acc <= sw_hit;
         dsi_req <= sw_hit & ~mck_sel;
         mchk_req <= sw_hit & mck_sel;
         // a compare waits in its flag while a higher exception is pending
         dbg_int_req <= (|dst_next) & evt_en & ~hi_pri_pending;
         halt_req <= hw_fin & halt_en;
         watch_out <= hw_fin & watch_en;
         irq <= |(ist_next & imask_reg);
      end
   end

   sequence s_sw_hit;
      acc_valid && sw_hit;
   endsequence
   sequence s_abort;
      verdict_valid && abort_acc;
   endsequence

   property p_cfg_w1;
      @(posedge pclk) disable iff (!presetn) wr_w1 |=> w1_reg == $past(pwdata);
   endproperty
   a_cfg_w1: assert property (p_cfg_w1) else $error("watchpoint one not loaded");

   property p_cmp_flag;
      @(posedge pclk) disable iff (!presetn) (|nrm_hit) |=> (|dst_reg) && ist_reg[`SLW_IB_CMP];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

   property p_hi_pri;
      @(posedge pclk) disable iff (!presetn) hi_pri_pending |=> !dbg_int_req;
   endproperty
   a_hi_pri: assert property (p_hi_pri) else $error("debug interrupt over higher priority");

   property p_ext_needed;
      @(posedge pclk) disable iff (!presetn) (st_reg == SLW_IDLE) && !ext_own |=> st_reg == SLW_IDLE;
   endproperty
   a_ext_needed: assert property (p_ext_needed) else $error("hardware check without ownership");

   property p_sw_noflag;
      @(posedge pclk) disable iff (!presetn)
         s_sw_hit ##0 (nrm_hit == 2'h0) |=> (dst_reg & ~$past(dst_reg)) == 2'h0;
   endproperty
   a_sw_noflag: assert property (p_sw_noflag) else $error("software hit set compare flag");

   property p_sw_abort;
      @(posedge pclk) disable iff (!presetn) s_sw_hit |=> s_abort ##0 (dsi_req != mchk_req);
   endproperty
   a_sw_abort: assert property (p_sw_abort) else $error("software hit not aborted");

   property p_mchk_pc;
      @(posedge pclk) disable iff (!presetn) s_sw_hit ##0 mck_sel |=> mchk_req && mpc_reg == $past(acc_pc);
   endproperty
   a_mchk_pc: assert property (p_mchk_pc) else $error("saved pc wrong");

   property p_halt;
      @(posedge pclk) disable iff (!presetn) hw_fin && halt_en |=> halt_req && (|est_reg);
   endproperty
   a_halt: assert property (p_halt) else $error("no halt on hardware hit");

   property p_late_flag;
      @(posedge pclk) disable iff (!presetn) (|(est_reg & ~$past(est_reg))) |-> $past(hw_fin);
   endproperty
   a_late_flag: assert property (p_late_flag) else $error("external flag before completion");

   property p_sp_qual;
      @(posedge pclk) disable iff (!presetn) (st_reg == SLW_IDLE) && !acc_sp_base |=> st_reg == SLW_IDLE;
   endproperty
   a_sp_qual: assert property (p_sp_qual) else $error("hardware hit without stack base");

   property p_exact;
      @(posedge pclk) disable iff (!presetn)
         acc_valid && dctl_reg[11:8] == 4'h0 && acc_addr != w1_reg && acc_addr != w2_reg |=> !abort_acc;
   endproperty
   a_exact: assert property (p_exact) else $error("abort off the limit address");

   property p_sw_wins;
      @(posedge pclk) disable iff (!presetn) s_sw_hit ##0 (st_reg == SLW_IDLE) |=> st_reg == SLW_IDLE;
   endproperty
   a_sw_wins: assert property (p_sw_wins) else $error("hardware event on aborted access");

   property p_priv;
      @(posedge pclk) disable iff (!presetn)
         acc_valid && acc_super && dctl_reg[7:4] == 4'hA |=> !abort_acc;
   endproperty
   a_priv: assert property (p_priv) else $error("user limit hit supervisor access");

   property p_type;
      @(posedge pclk) disable iff (!presetn)
         acc_valid && acc_write && !dctl_reg[1] && !dctl_reg[3] |=> !abort_acc;
   endproperty
   a_type: assert property (p_type) else $error("write hit with write compare off");

   property p_abort_verdict;
      @(posedge pclk) disable iff (!presetn) abort_acc |-> verdict_valid;
   endproperty
   a_abort_verdict: assert property (p_abort_verdict) else $error("abort outside verdict");

   property p_dsi_mode;
      @(posedge pclk) disable iff (!presetn) s_sw_hit ##0 !mck_sel |=> dsi_req && !mchk_req;
   endproperty
   a_dsi_mode: assert property (p_dsi_mode) else $error("software hit without data storage request");

   property p_hw_wait;
      @(posedge pclk) disable iff (!presetn) hw_hit |=> st_reg == SLW_WAIT;
   endproperty
   a_hw_wait: assert property (p_hw_wait) else $error("hardware hit not held for completion");

   property p_halt_late;
      @(posedge pclk) disable iff (!presetn) halt_req || watch_out |-> $past(hw_fin);
   endproperty
   a_halt_late: assert property (p_halt_late) else $error("debug outcome before completion");

   property p_sw_status;
      @(posedge pclk) disable iff (!presetn) s_sw_hit |=> ist_reg[`SLW_IB_DSI] || ist_reg[`SLW_IB_MCK];
   endproperty
   a_sw_status: assert property (p_sw_status) else $error("software hit left no status");

   property p_dbg_status;
      @(posedge pclk) disable iff (!presetn) dbg_int_req |-> (|dst_reg);
   endproperty
   a_dbg_status: assert property (p_dbg_status) else $error("debug interrupt without compare status");

endmodule // slw_top

// *** dv/slw_core_model.sv ***
// core load/store pipeline model: offers one access, takes the verdict, commits unless aborted
// assumes every signal is synchronous to pclk and the verdict follows one cycle after the offer
`timescale 1ns/1ps
module slw_core_model (
   input wire logic pclk,
   input wire logic verdict_valid,
   input wire logic abort_acc,
   input wire logic dsi_req,
   input wire logic mchk_req,
   input wire logic halt_req,
   input wire logic watch_out,
   output logic acc_valid,
   output slw_pkg::slw_word_t acc_addr,
   output slw_pkg::slw_word_t acc_data,
   output logic acc_write,
   output logic acc_super,
   output logic acc_sp_base,
   output slw_pkg::slw_word_t acc_pc,
   output logic acc_done
);
   import slw_pkg::*;
   logic [3:0] vflags;
   logic got_halt, got_watch, early, waiting;
   initial begin
      acc_valid = 1'b0;
      acc_done = 1'b0;
      {acc_write, acc_super, acc_sp_base} = 3'h0;
      {acc_addr, acc_data, acc_pc} = '0;
      waiting = 1'b0;
   end
   // debug outcomes are pulses, so they are latched for the bench
   always @(posedge pclk) begin
      if (halt_req === 1'b1) begin
         got_halt = 1'b1;
         early = early | waiting;
      end
      if (watch_out === 1'b1) begin
         got_watch = 1'b1;
      end
   end
   task automatic issue(input slw_word_t a, input slw_word_t d, input logic [2:0] wss, input int dly);
      {got_halt, got_watch, early} = 3'h0;
      @(posedge pclk);
      acc_valid <= 1'b1;
      {acc_write, acc_super, acc_sp_base} <= wss;
      {acc_addr, acc_data, acc_pc} <= {a, d, a + 32'h0000_0100};
      @(posedge pclk);
      acc_valid <= 1'b0;
      // released fields never keep their last value
      {acc_write, acc_super, acc_sp_base} <= ~wss;
      {acc_addr, acc_data, acc_pc} <= ~{a, d, a + 32'h0000_0100};
      @(posedge pclk);
      vflags = {verdict_valid, abort_acc, dsi_req, mchk_req};
      // an aborted access never commits, so memory and registers stay untouched
      if (abort_acc !== 1'b1) begin
         waiting = 1'b1;
         repeat (dly) @(posedge pclk);
         acc_done <= 1'b1;
         @(posedge pclk);
         waiting = 1'b0;
         acc_done <= 1'b0;
      end
   endtask
endmodule // slw_core_model

// *** dv/tb_top.sv ***
// self-checking bench: apb register tasks and core accesses on the stack limit watchpoint
// assumes slw_top answers apb with one wait state and the core model stands beside it
`timescale 1ns/1ps
`include "slw_params.svh"
module tb_top;
   import slw_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hi_pri_pending, rerr;
   logic [11:0] paddr;
   slw_word_t pwdata, prdata, acc_addr, acc_data, acc_pc, rdata;
   logic acc_valid, acc_write, acc_super, acc_sp_base, acc_done, verdict_valid, abort_acc;
   logic dsi_req, mchk_req, dbg_int_req, halt_req, watch_out, irq;
   int miscompares, check_count, cycles;
   slw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_data(acc_data), .acc_write(acc_write),
      .acc_super(acc_super), .acc_sp_base(acc_sp_base), .acc_pc(acc_pc), .acc_done(acc_done),
      .hi_pri_pending(hi_pri_pending), .verdict_valid(verdict_valid), .abort_acc(abort_acc),
      .dsi_req(dsi_req), .mchk_req(mchk_req), .dbg_int_req(dbg_int_req), .halt_req(halt_req),
      .watch_out(watch_out), .irq(irq));
   slw_core_model u_core (.pclk(pclk), .verdict_valid(verdict_valid), .abort_acc(abort_acc),
      .dsi_req(dsi_req), .mchk_req(mchk_req), .halt_req(halt_req), .watch_out(watch_out),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_data(acc_data), .acc_write(acc_write),
      .acc_super(acc_super), .acc_sp_base(acc_sp_base), .acc_pc(acc_pc), .acc_done(acc_done));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input slw_word_t got, input slw_word_t exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // a hung handshake is cut short here, well beyond the few hundred cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic apb(input logic [11:0] a, input logic w, input slw_word_t d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input slw_word_t d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input slw_word_t exp);
      apb(a, 1'b0, 32'h0000_0000);
      chk(rdata, exp);
   endtask
   // wss is {store, supervisor, stack pointer base}; vexp is {verdict, abort, dsi, mchk}
   task automatic acc(input slw_word_t a, input logic [2:0] wss, input int dly, input logic [3:0] vexp);
      u_core.issue(a, 32'h0000_0055, wss, dly);
      repeat (2) @(posedge pclk);
      chk(slw_word_t'(u_core.vflags), slw_word_t'(vexp));
   endtask
   initial begin
      {psel, penable, pwrite, hi_pri_pending, presetn} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`SLW_OFF_DCTL, 32'h0000_000F);
      rdchk(`SLW_OFF_AMASK, 32'hFFFF_FFFF);
      apb(12'h030, 1'b0, 32'h0000_0000);
      chk(slw_word_t'(rerr), 32'h0000_0001);
      wr(`SLW_OFF_W1, 32'h0000_1000);
      wr(`SLW_OFF_W2, 32'h0000_2000);
      rdchk(`SLW_OFF_W2, 32'h0000_2000);
      wr(`SLW_OFF_IMASK, 32'h0000_000F);
      wr(`SLW_OFF_CTRL, 32'h0000_0311);
      acc(32'h0000_1000, 3'b110, 0, 4'hD);
      rdchk(`SLW_OFF_MPC, 32'h0000_1100);
      rdchk(`SLW_OFF_DST, 32'h0000_0000);
      rdchk(`SLW_OFF_IST, 32'h0000_0002);
      chk(slw_word_t'(irq), 32'h0000_0001);
      wr(`SLW_OFF_IST, 32'h0000_000F);
      @(posedge pclk);
      chk(slw_word_t'(irq), 32'h0000_0000);
      acc(32'h0000_1004, 3'b110, 0, 4'h8);
      wr(`SLW_OFF_CTRL, 32'h0000_0301);
      wr(`SLW_OFF_IMASK, 32'h0000_0000);
      acc(32'h0000_2000, 3'b010, 0, 4'hE);
      chk(slw_word_t'(irq), 32'h0000_0000);
      rdchk(`SLW_OFF_IST, 32'h0000_0001);
      wr(`SLW_OFF_IMASK, 32'h0000_000F);
      // the mask lands at the write edge, the registered irq follows one edge later
      repeat (2) @(posedge pclk);
      chk(slw_word_t'(irq), 32'h0000_0001);
      wr(`SLW_OFF_IST, 32'h0000_000F);
      wr(`SLW_OFF_DCTL, 32'h0000_000D);
      acc(32'h0000_1000, 3'b110, 0, 4'h8);
      acc(32'h0000_1000, 3'b010, 0, 4'hE);
      wr(`SLW_OFF_DCTL, 32'h0000_009F);
      for (int i = 0; i < 4; i++) begin
         acc(i[1] ? 32'h0000_2000 : 32'h0000_1000, {1'b0, i[0], 1'b0}, 0, (i == 1 || i == 2) ? 4'hE : 4'h8);
      end
      wr(`SLW_OFF_DCTL, 32'h0000_00AF);
      acc(32'h0000_1000, 3'b010, 0, 4'h8);
      wr(`SLW_OFF_IST, 32'h0000_000F);
      wr(`SLW_OFF_DCTL, 32'h0000_000F);
      wr(`SLW_OFF_CTRL, 32'h0000_1163);
      acc(32'h0000_1000, 3'b011, 3, 4'h8);
      chk(slw_word_t'({u_core.got_halt, u_core.got_watch, u_core.early}), 32'h0000_0006);
      rdchk(`SLW_OFF_EST, 32'h0000_0001);
      rdchk(`SLW_OFF_IST, 32'h0000_0004);
      wr(`SLW_OFF_EST, 32'h0000_0003);
      wr(`SLW_OFF_IST, 32'h0000_000F);
      acc(32'h0000_1000, 3'b010, 1, 4'h8);
      chk(slw_word_t'(u_core.got_halt), 32'h0000_0000);
      wr(`SLW_OFF_CTRL, 32'h0000_1161);
      acc(32'h0000_1000, 3'b011, 1, 4'h8);
      chk(slw_word_t'(u_core.got_halt), 32'h0000_0000);
      wr(`SLW_OFF_W2, 32'h0000_1000);
      wr(`SLW_OFF_CTRL, 32'h0000_1373);
      acc(32'h0000_1000, 3'b011, 0, 4'hD);
      chk(slw_word_t'(u_core.got_halt), 32'h0000_0000);
      rdchk(`SLW_OFF_EST, 32'h0000_0000);
      wr(`SLW_OFF_W2, 32'h0000_2000);
      wr(`SLW_OFF_CTRL, 32'h0000_0008);
      wr(`SLW_OFF_AMASK, 32'hFFFF_FF00);
      wr(`SLW_OFF_DVAL, 32'h0000_0055);
      for (int m = 0; m < 3; m++) begin
         wr(`SLW_OFF_DCTL, 32'h0000_000F | (32'(m) << 8));
         acc(m == 1 ? 32'h0000_1010 : 32'h0000_1000, 3'b010, 0, 4'h8);
         rdchk(`SLW_OFF_DST, 32'h0000_0001);
         chk(slw_word_t'(dbg_int_req), 32'h0000_0001);
         wr(`SLW_OFF_DST, 32'h0000_0003);
      end
      wr(`SLW_OFF_DVAL, 32'h0000_0066);
      acc(32'h0000_1000, 3'b010, 0, 4'h8);
      rdchk(`SLW_OFF_DST, 32'h0000_0000);
      wr(`SLW_OFF_DCTL, 32'h0000_000F);
      hi_pri_pending <= 1'b1;
      acc(32'h0000_1000, 3'b010, 0, 4'h8);
      chk(slw_word_t'(dbg_int_req), 32'h0000_0000);
      hi_pri_pending <= 1'b0;
      rdchk(`SLW_OFF_DST, 32'h0000_0001);
      chk(slw_word_t'(dbg_int_req), 32'h0000_0001);
      give_verdict();
   end
endmodule // tb_top
